/* File: rtl/csm_cfg.svh */
`ifndef CSM_CFG_SVH
`define CSM_CFG_SVH
// ==========================================================
// register offsets (byte addresses)
`define CSM_OFS_CTRL      12'h000
`define CSM_OFS_SELECT    12'h004
`define CSM_OFS_STATUS    12'h008
`define CSM_OFS_PROFILE   12'h00c
`define CSM_OFS_PARAM     12'h100
`define CSM_OFS_LUT       12'h200
// ==========================================================
// field positions
`define CSM_CTRL_LOAD_BIT    0
`define CSM_CTRL_STORE_BIT   1
`define CSM_SEL_SRC_LSB      0
`define CSM_SEL_STARTUP_LSB  4
`define CSM_SEL_FACTORY_LSB  8
`define CSM_ST_BUSY_BIT      0
`define CSM_ST_REJECT_BIT    1
`define CSM_ST_READY_BIT     2
`define CSM_ST_IDLE_BIT      3
// ==========================================================
// reset values
`define CSM_RST_SRC       2'h3
`define CSM_RST_STARTUP   2'h3
`define CSM_RST_FACTORY   2'h0
`define CSM_RST_PROFILE   1'h0
// ==========================================================
// timing: description processing times in us
`define CSM_BASIC_US      100
`define CSM_FULL_US       400
`define CSM_CLK_MHZ       20
`endif

/* File: rtl/csm_pkg.sv */
package csm_pkg;
  // ==========================================================
  // set sources: user sets 1..3, default
  typedef enum logic [1:0] {
    CSM_USER1   = 2'h0,
    CSM_USER2   = 2'h1,
    CSM_USER3   = 2'h2,
    CSM_DEFAULT = 2'h3
  } csm_src_t;

  typedef enum logic {
    CSM_BASIC = 1'b0,
    CSM_FULL  = 1'b1
  } csm_profile_t;

  // ==========================================================
  // acquisition state and feature availability
  typedef struct packed {
    logic running;
    logic pending;
  } csm_acq_t;

  typedef struct packed {
    logic ready;
    logic color_matrix;
    logic color_adjust;
    logic sequencer;
  } csm_feat_t;
endpackage : csm_pkg

/* File: rtl/csm_sync.sv */
`timescale 1ns/1ps
module csm_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s1_d;
  logic [WIDTH-1:0] q_d;

  always_comb begin
    s1_d = d;
    q_d  = s1_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      q    <= '0;
    end else begin
      s1_q <= s1_d;
      q    <= q_d;
    end
  end
endmodule : csm_sync

/* File: rtl/csm_store.sv */
`timescale 1ns/1ps
`include "csm_cfg.svh"
// non-volatile store: 3 user sets and 4 factory setups, contents survive reset
module csm_store #(
  parameter int NPARAM = 8,
  parameter int AW     = 3
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [1:0]    wr_set,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [31:0]   wr_data,
  input  wire logic          rd_fact,
  input  wire logic [1:0]    rd_set,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [31:0]   rd_data
);
  import csm_pkg::*;
  logic [31:0] user_mem [3][NPARAM];
  logic [31:0] rd_d;

  // factory setups are fixed patterns: setup number in top byte, index below
  always_comb begin
    if (rd_fact) begin
      rd_d = {6'h00, rd_set, 24'h000000} | 32'(rd_idx);
    end else if (rd_set == 2'h3) begin
      rd_d = '0;
    end else begin
      rd_d = user_mem[rd_set][rd_idx];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && wr_set != 2'h3) begin
      user_mem[wr_set][wr_idx] <= wr_data;
    end
    rd_data <= rd_d;
  end
endmodule : csm_store

/* File: rtl/csm_top.sv */
`timescale 1ns/1ps
`include "csm_cfg.svh"
// How it works
// - load copies the selected stored set into every active parameter
// - load source is user set one, two, three or default
// - loads started through ctrl run only while no acquisition runs or is pending; the startup load does not wait
// - after reset the startup set is loaded automatically
// - startup source has its own selector, independent of load source
// - default set is the currently chosen factory setup
// - feature profile choice is persistent across resets
// - a new profile choice takes effect only after power cycle
// - basic profile disables colour matrix, colour adjust and sequencer
// - features usable after processing delay; basic is shorter
// - store writes active parameters into selected user set
// - lookup table is not stored and clears at reset
module csm_top #(
  parameter int NPARAM   = 8,
  parameter int NLUT     = 8,
  parameter int BASIC_CY = `CSM_BASIC_US * `CSM_CLK_MHZ,
  parameter int FULL_CY  = `CSM_FULL_US * `CSM_CLK_MHZ
) (
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          RST,
  // power-on event (whole power cycle, unlike RST)
  input  wire logic          POR,
  // apb slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [11:0]   PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // acquisition state pins
  input  wire logic          ACQ_RUNNING,
  input  wire logic          ACQ_PENDING,
  // active set and features
  output logic [NPARAM*32-1:0] ACTIVE_PARAMS,
  output csm_pkg::csm_feat_t   FEATURES
);
  import csm_pkg::*;
  localparam int AW = $clog2(NPARAM);
  localparam int LW = $clog2(NLUT);

  typedef enum logic [1:0] {CSM_S_IDLE, CSM_S_LOAD, CSM_S_STORE} csm_state_t;

  // ==========================================================
  // acquisition inputs from outside
  logic [1:0] acq_s;
  csm_acq_t   acq;
  csm_sync #(.WIDTH(2)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({ACQ_RUNNING, ACQ_PENDING}),
    .q   (acq_s)
  );
  assign acq = csm_acq_t'(acq_s);
  logic idle;
  assign idle = !acq.running && !acq.pending;

  // ==========================================================
  // state
  csm_state_t  st_q, st_d;
  logic [AW:0] idx_q, idx_d;
  logic [AW:0] wr_idx_q, wr_idx_d;
  logic        rd_vld_q, rd_vld_d;
  csm_src_t    src_q, src_d, startup_q, startup_d, cur_q, cur_d;
  logic [1:0]  factory_q, factory_d;
  logic        reject_q, reject_d;
  logic [31:0] act_q [NPARAM];
  logic [31:0] act_d [NPARAM];
  logic [31:0] lut_q [NLUT];
  logic [31:0] lut_d [NLUT];
  // persistent profile (ships basic, kept over power-on) and latched effective value
  csm_profile_t prof_nv_q = CSM_BASIC;
  csm_profile_t prof_nv_d, prof_eff_q, prof_eff_d;
  logic [31:0]  tmr_q, tmr_d;
  logic         feat_rdy_q, feat_rdy_d;
  logic [31:0]  prdata_d;
  logic         boot_q;
  logic         por_seen_q;

  logic [31:0] st_rdata;
  logic        apb_wr, apb_rd;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign apb_rd = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;

  logic map_hit;
  always_comb begin
    map_hit = (PADDR == `CSM_OFS_CTRL) || (PADDR == `CSM_OFS_SELECT) ||
              (PADDR == `CSM_OFS_STATUS) || (PADDR == `CSM_OFS_PROFILE) ||
              (PADDR[11:8] == 4'h1 && PADDR[7:2] < 6'(NPARAM) && PADDR[1:0] == 2'h0) ||
              (PADDR[11:8] == 4'h2 && PADDR[7:2] < 6'(NLUT) && PADDR[1:0] == 2'h0);
  end
  assign PSLVERR = PSEL && PENABLE && !map_hit;

  // ==========================================================
  // non-volatile store
  logic        nv_wr;
  logic        nv_fact;
  logic [1:0]  nv_rd_set;
  always_comb begin
    nv_fact   = (cur_q == CSM_DEFAULT);
    nv_rd_set = nv_fact ? factory_q : 2'(cur_q);
  end
  assign nv_wr = (st_q == CSM_S_STORE);
  csm_store #(.NPARAM(NPARAM), .AW(AW)) u_store (
    .clk     (CLK),
    .wr_en   (nv_wr),
    .wr_set  (2'(cur_q)),
    .wr_idx  (idx_q[AW-1:0]),
    .wr_data (act_q[idx_q[AW-1:0]]),
    .rd_fact (nv_fact),
    .rd_set  (nv_rd_set),
    .rd_idx  (idx_q[AW-1:0]),
    .rd_data (st_rdata)
  );

  // ==========================================================
  // sequencer, registers and features
  always_comb begin
    st_d       = st_q;
    idx_d      = idx_q;
    wr_idx_d   = wr_idx_q;
    rd_vld_d   = 1'b0;
    src_d      = src_q;
    startup_d  = startup_q;
    cur_d      = cur_q;
    factory_d  = factory_q;
    reject_d   = reject_q;
    act_d      = act_q;
    lut_d      = lut_q;
    prof_nv_d  = prof_nv_q;
    prof_eff_d = prof_eff_q;
    tmr_d      = tmr_q;
    feat_rdy_d = feat_rdy_q;
    prdata_d   = '0;

    unique case (st_q)
      CSM_S_IDLE: begin
        if (apb_wr && PADDR == `CSM_OFS_CTRL) begin
          if (PWDATA[`CSM_CTRL_LOAD_BIT]) begin
            if (idle) begin
              st_d     = CSM_S_LOAD;
              cur_d    = src_q;
              idx_d    = '0;
              reject_d = 1'b0;
            end else begin
              reject_d = 1'b1;
            end
          end else if (PWDATA[`CSM_CTRL_STORE_BIT] && src_q != CSM_DEFAULT) begin
            st_d  = CSM_S_STORE;
            cur_d = src_q;
            idx_d = '0;
          end
        end
      end
      CSM_S_LOAD: begin
        // one cycle read latency: index runs one ahead of the write
        rd_vld_d = (idx_q < (AW+1)'(NPARAM));
        wr_idx_d = idx_q;
        if (idx_q < (AW+1)'(NPARAM)) begin
          idx_d = idx_q + 1'b1;
        end
        if (rd_vld_q) begin
          act_d[wr_idx_q[AW-1:0]] = st_rdata;
        end
        if (!rd_vld_q && idx_q == (AW+1)'(NPARAM)) begin
          st_d = CSM_S_IDLE;
        end
      end
      CSM_S_STORE: begin
        idx_d = idx_q + 1'b1;
        if (idx_q == (AW+1)'(NPARAM - 1)) begin
          st_d = CSM_S_IDLE;
        end
      end
      default: st_d = CSM_S_IDLE;
    endcase

    // register writes
    if (apb_wr && st_q == CSM_S_IDLE) begin
      if (PADDR == `CSM_OFS_SELECT) begin
        src_d     = csm_src_t'(PWDATA[`CSM_SEL_SRC_LSB +: 2]);
        startup_d = csm_src_t'(PWDATA[`CSM_SEL_STARTUP_LSB +: 2]);
        if (idle) begin
          factory_d = PWDATA[`CSM_SEL_FACTORY_LSB +: 2];
        end
      end
      if (PADDR == `CSM_OFS_PROFILE) begin
        prof_nv_d = csm_profile_t'(PWDATA[0]);
      end
      if (PADDR[11:8] == 4'h1 && PADDR[7:2] < 6'(NPARAM)) begin
        act_d[PADDR[AW+1:2]] = PWDATA;
      end
    end
    if (apb_wr && PADDR[11:8] == 4'h2 && PADDR[7:2] < 6'(NLUT)) begin
      lut_d[PADDR[LW+1:2]] = PWDATA;
    end

    // feature description processing
    if (!feat_rdy_q) begin
      if (tmr_q == 32'h00000000) begin
        feat_rdy_d = 1'b1;
      end else begin
        tmr_d = tmr_q - 32'h00000001;
      end
    end

    // register reads
    if (apb_rd) begin
      if (PADDR == `CSM_OFS_SELECT) begin
        prdata_d = 32'({factory_q, 2'h0, 2'(startup_q), 2'h0, 2'(src_q)});
      end else if (PADDR == `CSM_OFS_STATUS) begin
        prdata_d = 32'({idle, feat_rdy_q, reject_q, st_q != CSM_S_IDLE});
      end else if (PADDR == `CSM_OFS_PROFILE) begin
        prdata_d = 32'({prof_eff_q, prof_nv_q});
      end else if (PADDR[11:8] == 4'h1 && PADDR[7:2] < 6'(NPARAM)) begin
        prdata_d = act_q[PADDR[AW+1:2]];
      end else if (PADDR[11:8] == 4'h2 && PADDR[7:2] < 6'(NLUT)) begin
        prdata_d = lut_q[PADDR[LW+1:2]];
      end
    end
  end

  always_ff @(posedge CLK) begin
    // power-on must not touch the stored profile, it only latches it below
    if (!POR) begin
      prof_nv_q <= prof_nv_d;
    end
    if (RST || POR) begin
      st_q       <= CSM_S_IDLE;
      idx_q      <= '0;
      wr_idx_q   <= '0;
      rd_vld_q   <= 1'b0;
      src_q      <= csm_src_t'(`CSM_RST_SRC);
      cur_q      <= CSM_DEFAULT;
      reject_q   <= 1'b0;
      for (int i = 0; i < NPARAM; i++) begin
        act_q[i] <= '0;
      end
      for (int i = 0; i < NLUT; i++) begin
        lut_q[i] <= '0;
      end
      boot_q     <= 1'b1;
    end else begin
      // first cycle after reset starts the startup load
      st_q       <= boot_q ? CSM_S_LOAD : st_d;
      idx_q      <= boot_q ? '0 : idx_d;
      cur_q      <= boot_q ? startup_q : cur_d;
      wr_idx_q   <= wr_idx_d;
      rd_vld_q   <= rd_vld_d;
      src_q      <= src_d;
      reject_q   <= reject_d;
      act_q      <= act_d;
      lut_q      <= lut_d;
      boot_q     <= 1'b0;
    end
    // startup and factory choices survive RST; power-on returns them to reset values
    if (POR) begin
      startup_q  <= csm_src_t'(`CSM_RST_STARTUP);
      factory_q  <= `CSM_RST_FACTORY;
      prof_eff_q <= CSM_BASIC;
      tmr_q      <= 32'(BASIC_CY);
      feat_rdy_q <= 1'b0;
      por_seen_q <= 1'b1;
    end else begin
      startup_q  <= startup_d;
      factory_q  <= factory_d;
      por_seen_q <= 1'b0;
      if (por_seen_q) begin
        // profile latched once per power cycle
        prof_eff_q <= prof_nv_q;
        tmr_q      <= (prof_nv_q == CSM_FULL) ? 32'(FULL_CY) : 32'(BASIC_CY);
        feat_rdy_q <= 1'b0;
      end else begin
        prof_eff_q <= prof_eff_d;
        tmr_q      <= tmr_d;
        feat_rdy_q <= feat_rdy_d;
      end
    end
  end
  assign PRDATA = prdata_d;

  // ==========================================================
  // outputs
  genvar g;
  generate
    for (g = 0; g < NPARAM; g++) begin : g_act
      assign ACTIVE_PARAMS[g*32 +: 32] = act_q[g];
    end
  endgenerate

  always_comb begin
    FEATURES.ready        = feat_rdy_q;
    FEATURES.color_matrix = feat_rdy_q && prof_eff_q == CSM_FULL;
    FEATURES.color_adjust = feat_rdy_q && prof_eff_q == CSM_FULL;
    FEATURES.sequencer    = feat_rdy_q && prof_eff_q == CSM_FULL;
  end
endmodule : csm_top

/* File: tb/csm_monitor.sv */
`timescale 1ns/1ps
module csm_monitor #(
  parameter int NPARAM   = 8,
  parameter int BASIC_CY = 10,
  parameter int FULL_CY  = 40
) (
  // clock and resets
  input wire logic                CLK,
  input wire logic                RST,
  input wire logic                POR,
  // apb
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PWRITE,
  input wire logic [11:0]         PADDR,
  input wire logic [31:0]         PWDATA,
  input wire logic [31:0]         PRDATA,
  input wire logic                PREADY,
  input wire logic                PSLVERR,
  // acquisition and outputs
  input wire logic                ACQ_RUNNING,
  input wire logic                ACQ_PENDING,
  input wire logic [NPARAM*32-1:0] ACTIVE_PARAMS,
  input wire csm_pkg::csm_feat_t  FEATURES
);
  import csm_pkg::*;
  // ==========================================================
  // cycles since power-on release
  int cnt_q;
  int cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (POR) cnt_d = 0;
    else if (cnt_q < FULL_CY + 31) cnt_d = cnt_q + 1;
  end
  always_ff @(posedge CLK) begin
    cnt_q <= cnt_d;
  end
  // ==========================================================
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence acq_busy_s;
    ACQ_RUNNING [*3];
  endsequence
  sequence load_wr_s;
    PSEL && PENABLE && PWRITE && PADDR == 12'h000 && PWDATA[0];
  endsequence
  pready_zero_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("pready low in access phase");
  slverr_map_a: assert property (PSEL && PENABLE && PADDR inside {12'h000, 12'h004,
      12'h008, 12'h00c} |-> !PSLVERR)
    else $error("error on mapped address");
  slverr_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access phase");
  feat_group_a: assert property (FEATURES.color_matrix == FEATURES.color_adjust &&
      FEATURES.color_adjust == FEATURES.sequencer)
    else $error("profile features split");
  feat_gate_a: assert property (!FEATURES.ready |-> !FEATURES.color_matrix)
    else $error("feature usable before ready");
  reject_hold_a: assert property (acq_busy_s ##0 load_wr_s |=> $stable(ACTIVE_PARAMS) [*8])
    else $error("active set changed on refused load");
  reset_clear_a: assert property (@(posedge CLK) disable iff (POR)
      RST ##1 RST |-> ACTIVE_PARAMS == '0)
    else $error("active set not cleared in reset");
  ready_early_a: assert property (FEATURES.ready |-> cnt_q >= BASIC_CY - 2)
    else $error("features ready too early");
  ready_bound_a: assert property (cnt_q == FULL_CY + 30 |-> FEATURES.ready)
    else $error("features never ready");
  profile_hold_a: assert property (FEATURES.ready && $past(FEATURES.ready) |->
      $stable(FEATURES.color_matrix))
    else $error("profile changed without power cycle");
endmodule : csm_monitor

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import csm_pkg::*;
  localparam int NP = 8;
  logic          CLK = 1'b0;
  logic          RST = 1'b1;
  logic          POR = 1'b1;
  logic          PSEL = 1'b0;
  logic          PENABLE = 1'b0;
  logic          PWRITE = 1'b0;
  logic [11:0]   PADDR = 12'h000;
  logic [31:0]   PWDATA = 32'h0;
  logic          ACQ_RUNNING = 1'b0;
  logic          ACQ_PENDING = 1'b0;
  logic [31:0]   PRDATA;
  logic          PREADY;
  logic          PSLVERR;
  logic [NP*32-1:0] ACTIVE_PARAMS;
  csm_feat_t     FEATURES;
  int            bad_count = 0;
  int            samples_checked = 0;
  always #25 CLK = ~CLK;
  csm_top #(.NPARAM(NP), .NLUT(8), .BASIC_CY(10), .FULL_CY(40)) dut_u (
    .CLK(CLK), .RST(RST), .POR(POR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .ACQ_RUNNING(ACQ_RUNNING),
    .ACQ_PENDING(ACQ_PENDING), .ACTIVE_PARAMS(ACTIVE_PARAMS), .FEATURES(FEATURES));
  // ==========================================================
  // helpers
  function automatic logic [31:0] pat(input int k, input int i);
    return {16'hc5a0, k[7:0], i[7:0]};
  endfunction : pat
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int   n;
    logic rdy;
    @(posedge CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n   = 0;
    rdy = 1'b0;
    r   = 32'h0;
    e   = 1'b0;
    // answer is taken at the rising edge where pready is seen high
    while (rdy !== 1'b1 && n < 16) begin
      @(posedge CLK);
      n++;
      rdy = PREADY;
      r   = PRDATA;
      e   = PSLVERR;
    end
    PSEL <= 1'b0; PENABLE <= 1'b0;
    if (rdy !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
  endtask : rd
  task idle;
    int          n;
    logic [31:0] r;
    logic        e;
    for (n = 0; n < 40; n++) begin
      apb(1'b0, 12'h008, 32'h0, r, e);
      if (r[0] === 1'b0) break;
    end
    if (n == 40) begin
      bad_count++;
      wrap_up();
    end
  endtask : idle
  task pulse(input logic p);
    @(posedge CLK);
    RST <= 1'b1; POR <= p;
    repeat (2) @(posedge CLK);
    RST <= 1'b0; POR <= 1'b0;
  endtask : pulse
  task wait_ready(output int n);
    n = 0;
    while (FEATURES.ready !== 1'b1 && n < 200) begin
      @(negedge CLK);
      n++;
    end
    if (FEATURES.ready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
  endtask : wait_ready
  // ==========================================================
  // main sequence
  initial begin
    int          nb;
    int          nf;
    int          i;
    int          k;
    logic [31:0] p0;
    logic [31:0] p1;
    logic        e;
    repeat (2) @(posedge CLK);
    RST <= 1'b0; POR <= 1'b0;
    wait_ready(nb);
    chk({28'h0, FEATURES}, 32'h8);
    idle;
    rd(12'h00c, 32'h3, 32'h0);
    rd(12'h004, 32'h333, 32'h033);
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < NP; i++) wr(12'h100 + 12'(4 * i), pat(k, i));
      wr(12'h004, 32'h30 | k);
      wr(12'h000, 32'h2);
      idle;
    end
    for (k = 2; k >= 0; k--) begin
      wr(12'h004, 32'h30 | k);
      wr(12'h000, 32'h1);
      idle;
      for (i = 0; i < NP; i++) rd(12'h100 + 12'(4 * i), 32'hffffffff, pat(k, i));
    end
    chk(ACTIVE_PARAMS[32*(NP-1)+:32], pat(0, NP - 1));
    ACQ_RUNNING <= 1'b1;
    repeat (4) @(posedge CLK);
    wr(12'h004, 32'h31);
    wr(12'h000, 32'h1);
    rd(12'h008, 32'h2, 32'h2);
    rd(12'h100, 32'hffffffff, pat(0, 0));
    ACQ_RUNNING <= 1'b0; ACQ_PENDING <= 1'b1;
    repeat (4) @(posedge CLK);
    wr(12'h000, 32'h1);
    rd(12'h008, 32'h2, 32'h2);
    rd(12'h100, 32'hffffffff, pat(0, 0));
    ACQ_PENDING <= 1'b0;
    repeat (4) @(posedge CLK);
    wr(12'h004, 32'h033);
    wr(12'h000, 32'h1);
    idle;
    apb(1'b0, 12'h100, 32'h0, p0, e);
    wr(12'h004, 32'h133);
    wr(12'h000, 32'h1);
    idle;
    apb(1'b0, 12'h100, 32'h0, p1, e);
    chk({31'h0, p0 !== p1}, 32'h1);
    wr(12'h004, 32'h013);
    wr(12'h200, 32'h5a5a0001);
    rd(12'h200, 32'hffffffff, 32'h5a5a0001);
    pulse(1'b0);
    idle;
    rd(12'h200, 32'hffffffff, 32'h0);
    for (i = 0; i < NP; i++) rd(12'h100 + 12'(4 * i), 32'hffffffff, pat(1, i));
    rd(12'h004, 32'h30, 32'h10);
    wr(12'h00c, 32'h1);
    rd(12'h00c, 32'h3, 32'h1);
    pulse(1'b0);
    idle;
    rd(12'h00c, 32'h3, 32'h1);
    chk({28'h0, FEATURES}, 32'h8);
    pulse(1'b1);
    wait_ready(nf);
    idle;
    rd(12'h00c, 32'h3, 32'h3);
    chk({28'h0, FEATURES}, 32'hf);
    chk({31'h0, nb < nf}, 32'h1);
    apb(1'b0, 12'h7f0, 32'h0, p0, e);
    chk({31'h0, e}, 32'h1);
    wrap_up();
  end
endmodule : tb
bind csm_top csm_monitor #(.NPARAM(NPARAM), .BASIC_CY(BASIC_CY), .FULL_CY(FULL_CY)) mon_u (
  .CLK(CLK), .RST(RST), .POR(POR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .ACQ_RUNNING(ACQ_RUNNING), .ACQ_PENDING(ACQ_PENDING),
  .ACTIVE_PARAMS(ACTIVE_PARAMS), .FEATURES(FEATURES));
